// ---- hdl/msid_core.v ----
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "msid_map.vh"
module msid_core (
   input wire clock,
   input wire reset,
   input wire instr_valid,
   input wire [9:0] instr,
   input wire [3:0] pointed_memory_nibble,
   input wire carry_in,
   input wire table_ref,
   input wire [1:0] table_high_bits,
   input wire [3:0] d_in,
   input wire s_axi_awvalid,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_wvalid,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_rready,
   output reg s_axi_awready,
   output reg s_axi_wready,
   output reg s_axi_bvalid,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_arready,
   output reg s_axi_rvalid,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg pc_advance,
   output reg exec_suppressed,
   output reg carry_out,
   output reg [3:0] d_out,
   output reg d_write,
   output reg upper_table_ref_flag,
   output reg voltage_detect_enable
);
   // ==========================================
   // Decode
   wire is_set_upper;
   wire is_vdet_en;
   wire is_skip_bit;
   wire is_skip_carry;
   reg skip_pending_reg;
   reg hvar_reg;
   reg [9:0] last_instr_reg;
   reg aw_got_reg;
   reg w_got_reg;
   reg [3:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg w_strb0_reg;
   wire exec;
   wire skip_now;
   wire clr_upper;
   wire do_write;
   reg [31:0] rdata_next;
   reg [1:0] rresp_next;

   msid_decode u_dec (
      .instr(instr),
      .is_set_upper(is_set_upper),
      .is_vdet_en(is_vdet_en),
      .is_skip_bit(is_skip_bit),
      .is_skip_carry(is_skip_carry)
   );

   // ==========================================
   // Register address check, shared by both channels
   // All four word slots are mapped, so only alignment can fail
   function msid_addr_ok;
      input [3:0] addr;
      begin
         msid_addr_ok = (addr[1:0] == 2'b00);
      end
   endfunction

   // Skipped slot executes nothing
   assign exec = instr_valid & ~skip_pending_reg;
   assign skip_now = exec & ((is_skip_bit & ~pointed_memory_nibble[instr[1:0]]) |
                             (is_skip_carry & ~carry_in));
   assign do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   assign clr_upper = do_write & w_strb0_reg & (aw_addr_reg == `MSID_REG_CTRL) &
                      w_data_reg[`MSID_CTRL_CLR_UPPER_BIT];

   // ==========================================
   // Execute
   always @(posedge clock) begin
      if (reset) begin
         skip_pending_reg <= 1'b0;
         upper_table_ref_flag <= 1'b0;
         voltage_detect_enable <= 1'b0;
         pc_advance <= 1'b0;
         exec_suppressed <= 1'b0;
         carry_out <= 1'b0;
         d_out <= 4'h0;
         d_write <= 1'b0;
         last_instr_reg <= 10'h000;
      end else begin
         // Program counter moves on every slot, skipped or not
         pc_advance <= instr_valid;
         exec_suppressed <= instr_valid & skip_pending_reg;
         carry_out <= carry_in;
         if (instr_valid) begin
            skip_pending_reg <= skip_now;
            last_instr_reg <= instr;
         end
         // Set wins over a software clear in the same cycle
         if (exec & is_set_upper) begin
            upper_table_ref_flag <= 1'b1;
         end else if (clr_upper) begin
            upper_table_ref_flag <= 1'b0;
         end
         if (exec & is_vdet_en & hvar_reg) begin
            voltage_detect_enable <= 1'b1;
         end
         d_write <= exec & table_ref & upper_table_ref_flag;
         if (exec & table_ref & upper_table_ref_flag) begin
            d_out <= {d_in[3:2], table_high_bits};
         end
      end
   end

   // ==========================================
   // AXI4-Lite slave, one write and one read at a time
   always @(posedge clock) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MSID_RESP_OKAY;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h0000_0000;
         w_strb0_reg <= 1'b0;
         hvar_reg <= 1'b0;
      end else begin
         // Ready pulses one cycle so a held valid is taken only once
         s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb0_reg <= s_axi_wstrb[0];
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= msid_addr_ok(aw_addr_reg) ? `MSID_RESP_OKAY : `MSID_RESP_SLVERR;
            // Only the control word is writable; the rest ignore data
            if (w_strb0_reg && aw_addr_reg == `MSID_REG_CTRL) begin
               hvar_reg <= w_data_reg[`MSID_CTRL_HVAR_BIT];
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // Read data select
   // Status shows live carry, so a read reflects the slot it lands in
   always @* begin
      rdata_next = 32'h0000_0000;
      rresp_next = `MSID_RESP_OKAY;
      if (!msid_addr_ok(s_axi_araddr)) begin
         rresp_next = `MSID_RESP_SLVERR;
      end else begin
         case (s_axi_araddr)
            `MSID_REG_CTRL: begin
               rdata_next = {31'h0000_0000, hvar_reg};
            end
            `MSID_REG_STATUS: begin
               rdata_next = {28'h000_0000, skip_pending_reg, carry_in, voltage_detect_enable,
                             upper_table_ref_flag};
            end
            `MSID_REG_INSTR: begin
               rdata_next = {22'h00_0000, last_instr_reg};
            end
            `MSID_REG_TABLE: begin
               rdata_next = {28'h000_0000, d_out};
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // ==========================================
   // Read channel
   // New address is refused while a read answer still waits
   always @(posedge clock) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `MSID_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rresp_next;
            s_axi_rdata <= rdata_next;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // msid_core

// ---- hdl/msid_decode.v ----
`timescale 1ns/1ps
`include "msid_map.vh"
// Pure decoder for the four instructions
module msid_decode (
   input wire [9:0] instr,
   output wire is_set_upper,
   output wire is_vdet_en,
   output wire is_skip_bit,
   output wire is_skip_carry
);
   assign is_set_upper = (instr == `MSID_OP_SET_UPPER);
   assign is_vdet_en = (instr == `MSID_OP_VDET_EN);
   assign is_skip_bit = ((instr & `MSID_OP_SKIP_BIT_MASK) == `MSID_OP_SKIP_BIT);
   assign is_skip_carry = (instr == `MSID_OP_SKIP_CARRY);
endmodule // msid_decode

// ---- hdl/msid_map.vh ----
`ifndef MSID_MAP_VH
`define MSID_MAP_VH
`define MSID_OP_SET_UPPER 10'h05B
`define MSID_OP_VDET_EN 10'h293
`define MSID_OP_SKIP_BIT 10'h020
`define MSID_OP_SKIP_BIT_MASK 10'h3FC
`define MSID_OP_SKIP_CARRY 10'h02F
`define MSID_REG_CTRL 4'h0
`define MSID_REG_STATUS 4'h4
`define MSID_REG_INSTR 4'h8
`define MSID_REG_TABLE 4'hC
`define MSID_CTRL_HVAR_BIT 0
`define MSID_CTRL_CLR_UPPER_BIT 1
`define MSID_RESP_OKAY 2'b00
`define MSID_RESP_SLVERR 2'b10
`endif

// ---- tb/msid_core_asserts.sv ----
`timescale 1ns/1ps
`include "msid_map.vh"
// ====
// Slot checks
module msid_chk (
   input wire clock,
   input wire reset,
   input wire instr_valid,
   input wire [9:0] instr,
   input wire [3:0] pointed_memory_nibble,
   input wire carry_in,
   input wire table_ref,
   input wire pc_advance,
   input wire exec_suppressed,
   input wire carry_out,
   input wire d_write,
   input wire upper_table_ref_flag,
   input wire voltage_detect_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   reg skip_reg;
   wire ex = instr_valid && !skip_reg;
   wire su = ex && instr == `MSID_OP_SET_UPPER;
   wire hit = instr == `MSID_OP_SKIP_CARRY && !carry_in || (instr & `MSID_OP_SKIP_BIT_MASK)
      == `MSID_OP_SKIP_BIT && !pointed_memory_nibble[instr[1:0]];
   // Idle slots keep a pending skip
   always @(posedge clock) skip_reg <= reset ? 1'b0 : instr_valid ? ex && hit : skip_reg;
   a_pc_adv: assert property (instr_valid |=> pc_advance) else $error("adv");
   a_idle_slot: assert property (!instr_valid |=> !pc_advance) else $error("idle");
   a_skip_nop: assert property (instr_valid && !ex |=> exec_suppressed && !d_write)
      else $error("nop");
   a_no_skip: assert property (ex |=> !exec_suppressed) else $error("run");
   a_set_upper: assert property (su |=> upper_table_ref_flag) else $error("flag");
   a_table_d: assert property (ex && table_ref && upper_table_ref_flag |=> d_write)
      else $error("d");
   a_carry_keep: assert property (1 |=> carry_out == $past(carry_in)) else $error("cy");
   a_vdet_hold: assert property (voltage_detect_enable |=> voltage_detect_enable)
      else $error("vd");
   cover property (ex && hit);
   cover property (ex && table_ref && upper_table_ref_flag);
   cover property (ex && instr == `MSID_OP_VDET_EN);
endmodule // msid_chk
bind msid_core msid_chk u_chk (.*);

// ---- tb/msid_core_tb.sv ----
`timescale 1ns/1ps
`include "msid_map.vh"
// ====
// Random slots against a reference model
module msid_core_tb;
   bit clock, instr_valid, carry_in, table_ref, skp, flg, vd, hv;
   bit reset = 1;
   bit [1:0] table_high_bits;
   bit [2:0] addr;
   bit [3:0] pointed_memory_nibble, d_in, s_axi_awaddr, s_axi_araddr, eo;
   bit [3:0] s_axi_wstrb = 4'hF;
   bit [4:0] p, hs;
   bit [31:0] s_axi_wdata = 32'h0000_0001;
   bit [31:0] r, rd;
   wire s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pc_advance;
   logic exec_suppressed, carry_out, d_write, upper_table_ref_flag, voltage_detect_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   logic [3:0] d_out;
   logic [9:0] instr;
   logic [31:0] s_axi_rdata;
   logic [5:0] e;
   wire [5:0] got = {pc_advance, exec_suppressed, carry_out, d_write, upper_table_ref_flag,
      voltage_detect_enable};
   int miscompares, num_checks;
   assign {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = hs;
   msid_core DUT (.*);
   msid_pmem u_pmem (.addr(addr), .word(instr));
   always #25 clock = ~clock;
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Write and read run side by side; each channel drops alone
   task axi(input bit [3:0] wa, input bit [3:0] ra);
      @(posedge clock);
      {s_axi_awaddr, s_axi_araddr} <= {wa, ra};
      p = 5'h1F;
      while (p[1:0] != 2'h0) begin
         hs <= p;
         @(posedge clock);
         if (p[1] && s_axi_bvalid) br = s_axi_bresp;
         if (p[0] && s_axi_rvalid) {rr, rd} = {s_axi_rresp, s_axi_rdata};
         p = p & ~{s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid};
      end
      hs <= 5'h00;
   endtask
   task run(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         eo = {d_in[3:2], table_high_bits};
         e[5:2] = {instr_valid, instr_valid && skp, carry_in, instr_valid && !skp && table_ref && flg};
         if (instr_valid && !skp) begin
            flg = flg || instr == `MSID_OP_SET_UPPER;
            vd = vd || hv && instr == `MSID_OP_VDET_EN;
            skp = instr == `MSID_OP_SKIP_CARRY && !carry_in || (instr & `MSID_OP_SKIP_BIT_MASK)
               == `MSID_OP_SKIP_BIT && !pointed_memory_nibble[instr[1:0]];
         end else if (instr_valid) skp = 0;
         e[1:0] = {flg, vd};
         r = $urandom;
         {addr, pointed_memory_nibble, table_high_bits, d_in, carry_in} <= r[13:0];
         instr_valid <= r[14] && i < n - 1;
         table_ref <= &r[15:13];
         #1;
         chk("slot", e, got);
         if (e[2]) chk("d_out", eo, d_out);
      end
   endtask
   initial begin
      void'($urandom(32'ha5f5_d946));
      repeat (12) @(posedge clock);
      reset <= 0;
      run(80);
      $display("test hvar_off done");
      axi(`MSID_REG_CTRL, 4'h2);
      chk("resp", {`MSID_RESP_OKAY, `MSID_RESP_SLVERR}, {br, rr});
      chk("rdata", 32'h0000_0000, rd);
      hv = 1;
      run(80);
      $display("test hvar_on done");
      axi(`MSID_REG_STATUS, `MSID_REG_STATUS);
      chk("resp", {`MSID_RESP_OKAY, `MSID_RESP_OKAY}, {br, rr});
      chk("status", {28'h000_0000, skp, carry_in, vd, flg}, rd);
      $display("test status done");
      close_out;
   end
   initial begin
      #50000;
      miscompares++;
      close_out;
   end
endmodule // msid_core_tb

// ---- tb/msid_pmem.sv ----
`timescale 1ns/1ps
`include "msid_map.vh"
// ====
// Fixed program words
module msid_pmem (
   input wire [2:0] addr,
   output wire [9:0] word
);
   assign word = addr[2] ? `MSID_OP_SKIP_BIT | addr[1:0] : addr[1] ? {10{!addr[0]}} &
      `MSID_OP_VDET_EN : addr[0] ? `MSID_OP_SET_UPPER : `MSID_OP_SKIP_CARRY;
endmodule // msid_pmem
